// ### pattern_match_slice_source_select_test.sv
// Self-checking testbench of the slice source-select stage.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
  n_errors++; $display("Error %s expected %h seen %h", nm, exp, got); end end
module pattern_match_slice_source_select_test;
  typedef struct packed {
    logic [1:0] kind;
    logic [31:0] val;
  } pmss_note_t;
  localparam logic [11:0] A_SRC = pmss_pkg::OFS_SLICE_INPUT_SELECT;
  localparam logic [11:0] A_CFG = pmss_pkg::OFS_SLICE_CONDITION_CONFIG;
  localparam logic [11:0] A_CTL = pmss_pkg::OFS_MATCH_CONTROL;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic chk = 1'b0;
  logic chk_d = 1'b0;
  logic dp_rd = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] pins = 8'h01;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic hist_clear;
  logic match_mode_select;
  logic cpu_event_enable;
  pmss_pkg::pmss_slice_bus_t slice_bus;
  int n_errors = 0;
  int n_compared = 0;
  pmss_note_t q[$];
  logic [31:0] seed = 32'h48996e4a;
  string nm[4] = '{"hrdata", "level", "control", "sticky"};

  always #10 hclk = ~hclk;

  pmss_top pmss_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pin_choice_in(pins), .slice_bus(slice_bus),
    .hist_clear(hist_clear), .match_mode_select(match_mode_select),
    .cpu_event_enable(cpu_event_enable)
  );

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // One bus transfer: the address phase, then its data phase.
  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    dp_rd <= ~w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    dp_rd <= 1'b0;
  endtask : ahb

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back('{2'h0, e});
    ahb(1'b0, a, 32'h0);
  endtask : rd

  // A note toggles chk, so back-to-back notes never assign it twice at once.
  task automatic note(input logic [1:0] k, input logic [31:0] v);
    q.push_back('{k, v});
    chk <= ~chk;
    @(posedge hclk);
  endtask : note

  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt

  task results;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  always @(posedge hclk) begin : mon
    pmss_note_t e;
    logic [31:0] got;
    chk_d <= chk;
    if ((dp_rd && hreadyout === 1'b1) || (chk !== chk_d)) begin
      e = q.pop_front();
      case (e.kind)
        2'h0: got = hrdata;
        2'h1: got = {24'h0, slice_bus.level};
        2'h2: got = {29'h0, hist_clear, match_mode_select, cpu_event_enable};
        default: got = {16'h0, slice_bus.rise_seen, slice_bus.fall_seen};
      endcase
      `CHK(nm[e.kind], e.val, got)
      `CHK("hreadyout", 1'b1, hreadyout)
      if (e.kind == 2'h0)
        `CHK("hresp", 1'b0, hresp)
    end
  end

  initial begin : main
    logic [31:0] src;
    logic [7:0] lvl;
    wt(3);
    hresetn <= 1'b1;
    wt(8);
    note(2'h2, 32'h4);
    note(2'h1, 32'hff);
    rd(A_SRC, 32'h0);
    rd(12'h100, 32'h0);
    ahb(1'b1, A_CTL, 32'h1);
    wt(2);
    note(2'h2, 32'h2);
    rd(A_CTL, 32'h1);
    ahb(1'b1, A_CFG, 32'hffffffff);
    rd(A_CFG, ~pmss_pkg::CFG_RSVD_MASK);
    // First eight passes walk every code through every slice.
    for (int k = 0; k < 14; k++) begin
      seed = xs(seed);
      src = 32'h0;
      for (int j = 0; j < 8; j++)
        src[8+3*j +: 3] = (k < 8) ? 3'(j + k) : seed[3*j +: 3];
      ahb(1'b1, A_SRC, src);
      note(2'h2, 32'h6);
      rd(A_SRC, src);
      pins <= seed[31:24];
      for (int j = 0; j < 8; j++)
        lvl[j] = seed[24 + src[8+3*j +: 3]];
      wt(8);
      note(2'h1, {24'h0, lvl});
    end
    ahb(1'b1, A_SRC, 32'h0);
    pins <= 8'h00;
    wt(8);
    ahb(1'b1, A_CFG, 32'h0);
    wt(3);
    note(2'h3, 32'h0);
    pins <= 8'h01;
    wt(8);
    note(2'h3, 32'hff00);
    pins <= 8'h00;
    wt(8);
    note(2'h3, 32'hffff);
    ahb(1'b1, A_SRC, 32'h0);
    wt(3);
    note(2'h3, 32'h0);
    pins <= 8'h01;
    wt(8);
    ahb(1'b1, A_CTL, 32'h0);
    wt(3);
    note(2'h2, 32'h4);
    note(2'h3, 32'h0);
    ahb(1'b1, A_CTL, 32'h2);
    wt(2);
    note(2'h2, 32'h1);
    rd(A_CTL, 32'h2);
    wt(2);
    results;
  end

  // The run needs well under a thousand cycles; this catches a hang.
  initial begin : watchdog
    #50us;
    n_errors++;
    $display("Error watchdog expected done seen hang");
    results;
  end
endmodule : pattern_match_slice_source_select_test

// ### pmss_pin_sync.sv
// Three-stage synchroniser for the eight selected pin inputs.
`timescale 1ns/10ps
module pmss_pin_sync (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Raw and settled pins
  input wire logic [7:0] pin_raw,
  output logic [7:0] pin_clean
);
  logic [7:0] s1_ff;
  logic [7:0] s2_ff;
  logic [7:0] s3_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff <= 8'h00;
      s2_ff <= 8'h00;
      s3_ff <= 8'h00;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A bit only moves once the last two stages agree, which rejects glitches.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_clean <= 8'h00;
    end else begin
      pin_clean <= (s2_ff & s3_ff) | (pin_clean & (s2_ff ^ s3_ff));
    end
  end
endmodule : pmss_pin_sync

// ### pmss_pkg.sv
// Shared constants and carrier types of the slice source-select stage.
package pmss_pkg;
  localparam int ADDR_W = 12;
  localparam int NUM_SLICES = 8;
  localparam int SEL_W = 3;
  localparam int SEL_LSB = 8;
  localparam logic [ADDR_W-1:0] OFS_MATCH_CONTROL = 12'h028;
  localparam logic [ADDR_W-1:0] OFS_SLICE_INPUT_SELECT = 12'h02c;
  localparam logic [ADDR_W-1:0] OFS_SLICE_CONDITION_CONFIG = 12'h030;
  localparam logic [31:0] RST_SLICE_INPUT_SELECT = 32'h0000_0000;
  localparam logic [31:0] RST_SLICE_CONDITION_CONFIG = 32'h0000_0000;
  localparam logic [1:0] RST_MATCH_CONTROL = 2'h0;
  localparam logic [31:0] SRC_RSVD_MASK = 32'h0000_00ff;
  localparam logic [31:0] CFG_RSVD_MASK = 32'h0000_0080;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_EVENT_BIT = 1;

  typedef struct packed {
    logic [NUM_SLICES-1:0] level;
    logic [NUM_SLICES-1:0] rise_seen;
    logic [NUM_SLICES-1:0] fall_seen;
  } pmss_slice_bus_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
  } pmss_ahb_req_t;
endpackage : pmss_pkg

// ### pmss_slice.sv
// Per-slice input multiplexers and sticky edge-detect history.
`timescale 1ns/10ps
module pmss_slice (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Inputs and selectors
  input wire logic [7:0] pin_clean,
  input wire logic [23:0] sel_word,
  input wire logic hist_clear,
  // Slice results
  output pmss_pkg::pmss_slice_bus_t slice_out
);
  logic [7:0] prev_ff;

  for (genvar k = 0; k < pmss_pkg::NUM_SLICES; k++) begin : g_slice
    logic [2:0] sel;
    assign sel = sel_word[k*pmss_pkg::SEL_W +: pmss_pkg::SEL_W];

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        slice_out.level[k] <= 1'b0;
        prev_ff[k] <= 1'b0;
      end else begin
        slice_out.level[k] <= pin_clean[sel]; // RULE2 RULE4
        prev_ff[k] <= slice_out.level[k];
      end
    end

    // An edge arriving while history is cleared still counts.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        slice_out.rise_seen[k] <= 1'b0;
        slice_out.fall_seen[k] <= 1'b0;
      end else begin
        if (slice_out.level[k] && !prev_ff[k]) begin
          slice_out.rise_seen[k] <= 1'b1; // RULE8
        end else if (hist_clear) begin
          slice_out.rise_seen[k] <= 1'b0;
        end
        if (!slice_out.level[k] && prev_ff[k]) begin
          slice_out.fall_seen[k] <= 1'b1; // RULE8
        end else if (hist_clear) begin
          slice_out.fall_seen[k] <= 1'b0;
        end
      end
    end
  end
endmodule : pmss_slice

// ### pmss_top.sv
// AHB-Lite register slave and top of the slice source-select stage.
// How it works
// RULE1: Eight slices, each with a selector; all selectors reset to input 0.
// RULE2: Each 3-bit selector value 0..7 routes that input; slice 0 at 10:8.
// RULE3: Slice k selector at bits 8+3k..10+3k; slice 7 at 31:29.
// RULE4: Input n is the pin chosen by the nth external pin-select register.
// RULE5: Any write to source or configuration register clears edge history.
// RULE6: Mode select and CPU event enable both zero erases edge history.
// RULE7: Software writes only zeros to source register bits 7:0.
// RULE8: A sticky edge result stays high until history is cleared.
// RULE9: Mode select picks pin or pattern interrupts; resets to pin mode.
// RULE10: Source register reads back last selectors; reserved bits read zero.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/10ps
module pmss_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pins chosen by the external pin-select registers
  input wire logic [7:0] pin_choice_in,
  // To the rest of the pattern-match unit
  output pmss_pkg::pmss_slice_bus_t slice_bus,
  output logic hist_clear,
  output logic match_mode_select,
  output logic cpu_event_enable
);
  pmss_pkg::pmss_ahb_req_t req_ff;
  logic [31:0] src_ff;
  logic [31:0] cfg_ff;
  logic [1:0] ctrl_ff;
  logic [31:0] nxt_src;
  logic [31:0] nxt_cfg;
  logic [1:0] nxt_ctrl;
  logic [31:0] rd_value;
  logic [7:0] pin_clean;
  logic acc;
  logic wr_now;
  logic wr_src;
  logic wr_cfg;
  logic wr_ctrl;

  // Only whole-word single transfers are expected, so hsize is not decoded.
  assign acc = hsel && htrans[1] && hready;
  assign wr_now = req_ff.valid && req_ff.write;
  assign wr_src = wr_now && (req_ff.addr == pmss_pkg::OFS_SLICE_INPUT_SELECT);
  assign wr_cfg = wr_now &&
                  (req_ff.addr == pmss_pkg::OFS_SLICE_CONDITION_CONFIG);
  assign wr_ctrl = wr_now && (req_ff.addr == pmss_pkg::OFS_MATCH_CONTROL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_ff <= '0;
    end else if (hready) begin
      req_ff.valid <= acc;
      req_ff.write <= hwrite;
      req_ff.addr <= haddr[pmss_pkg::ADDR_W-1:0];
    end
  end

  // Next values double as a forwarding path for a read right after a write.
  always_comb begin
    nxt_src = src_ff;
    nxt_cfg = cfg_ff;
    nxt_ctrl = ctrl_ff;
    if (wr_src) begin
      nxt_src = hwdata & ~pmss_pkg::SRC_RSVD_MASK; // RULE7 RULE10
    end
    if (wr_cfg) begin
      nxt_cfg = hwdata & ~pmss_pkg::CFG_RSVD_MASK;
    end
    if (wr_ctrl) begin
      nxt_ctrl = hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_ff <= pmss_pkg::RST_SLICE_INPUT_SELECT; // RULE1
    end else begin
      src_ff <= nxt_src; // RULE3
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff <= pmss_pkg::RST_SLICE_CONDITION_CONFIG;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= pmss_pkg::RST_MATCH_CONTROL;
      match_mode_select <= 1'b0;
      cpu_event_enable <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      match_mode_select <= nxt_ctrl[pmss_pkg::CTRL_MODE_BIT]; // RULE9
      cpu_event_enable <= nxt_ctrl[pmss_pkg::CTRL_EVENT_BIT];
    end
  end

  // Disabled matching keeps the history in clear, which also saves power.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hist_clear <= 1'b1;
    end else begin
      hist_clear <= wr_src || wr_cfg || (ctrl_ff == 2'h0); // RULE5 RULE6
    end
  end

  // Product-term match state lives elsewhere, so its field reads zero here.
  always_comb begin
    rd_value = 32'h0000_0000;
    case (haddr[pmss_pkg::ADDR_W-1:0])
      pmss_pkg::OFS_SLICE_INPUT_SELECT: rd_value = nxt_src; // RULE10
      pmss_pkg::OFS_SLICE_CONDITION_CONFIG: rd_value = nxt_cfg;
      pmss_pkg::OFS_MATCH_CONTROL: rd_value = {30'h0, nxt_ctrl};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      hrdata <= rd_value;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  pmss_pin_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_raw(pin_choice_in),
    .pin_clean(pin_clean)
  );

  pmss_slice u_slice (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_clean(pin_clean),
    .sel_word(src_ff[31:pmss_pkg::SEL_LSB]),
    .hist_clear(hist_clear),
    .slice_out(slice_bus)
  );

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_read_src;
    acc && !hwrite && !wr_now &&
    (haddr[11:0] == pmss_pkg::OFS_SLICE_INPUT_SELECT);
  endsequence

  sequence s_ctrl_write;
    acc && hwrite && (haddr[11:0] == pmss_pkg::OFS_MATCH_CONTROL) ##1 1'b1;
  endsequence

  AST_SRC_HOLDS: assert property ( // RULE1
    !wr_src |=> src_ff == $past(src_ff))
    else $error("Source register changed without a write.");
  AST_SLICE0_ROUTE: assert property ( // RULE2
    ##1 slice_bus.level[0] == $past(pin_clean[src_ff[10:8]]))
    else $error("Slice 0 does not follow its selected input.");
  AST_SLICE7_ROUTE: assert property ( // RULE3
    ##1 slice_bus.level[7] == $past(pin_clean[src_ff[31:29]]))
    else $error("Slice 7 does not follow its selected input.");
  AST_PIN_SETTLE: assert property ( // RULE4
    $changed(pin_clean) |-> $past(pin_choice_in, 3) != $past(pin_clean))
    else $error("Settled pin moved without a pin change.");
  AST_WRITE_CLEARS: assert property ( // RULE5
    (wr_src || wr_cfg) |=> hist_clear)
    else $error("Register write did not clear edge history.");
  AST_DISABLE_CLEARS: assert property ( // RULE6
    (ctrl_ff == 2'h0) |=> hist_clear)
    else $error("Disabled matching did not clear edge history.");
  AST_RSVD_ZERO: assert property ( // RULE7
    src_ff[7:0] == 8'h00)
    else $error("Reserved source bits are not zero.");
  AST_STICKY_HOLD: assert property ( // RULE8
    slice_bus.rise_seen[0] && !hist_clear |=> slice_bus.rise_seen[0])
    else $error("Sticky rising result dropped without a clear.");
  AST_MODE_WRITE: assert property ( // RULE9
    s_ctrl_write |=> match_mode_select == $past(hwdata[0]))
    else $error("Mode select did not take the written value.");
  AST_READBACK: assert property ( // RULE10
    s_read_src |=> hrdata == ($past(src_ff) & ~pmss_pkg::SRC_RSVD_MASK))
    else $error("Source register read returned a wrong value.");
endmodule : pmss_top
